/* File: ats_sel_pkg.sv */
package ats_sel_pkg;

	// Answer-to-select bytes
	localparam logic [7:0] RATS_START = 8'hE0;
	localparam logic [7:0] ATS_TL = 8'h05;
	localparam logic [7:0] ATS_T0 = 8'h78;
	localparam logic [7:0] ATS_TA = 8'h80;
	localparam logic [3:0] ATS_SFGI = 4'h0;
	localparam logic [7:0] ATS_TC = 8'h00;
	localparam logic [2:0] ATS_LAST = 3'h4;
	localparam logic [3:0] FWI_MIN = 4'h1;
	localparam logic [3:0] FWI_MAX = 4'hE;
	localparam logic [3:0] FWI_RST = 4'h4;

	// File-selection command fields
	localparam logic [7:0] CLA_ISO = 8'h00;
	localparam logic [7:0] INS_SELECT = 8'hA4;
	localparam logic [15:0] PAIR_EF = 16'h020C;
	localparam logic [15:0] PAIR_AID = 16'h0400;
	localparam logic [15:0] PAIR_FID = 16'h000C;
	localparam logic [7:0] LC_AID = 8'h07;
	localparam logic [7:0] LC_OTHER = 8'h02;
	localparam logic [55:0] AID_VALUE = 56'hD2760000850101;
	localparam logic [15:0] FID_CC = 16'hE103;
	localparam logic [15:0] FID_NDEF = 16'h0103;
	localparam logic [7:0] LE_AID = 8'h00;
	localparam logic [7:0] HDR_LEN = 8'h05;

	// Status words per outcome
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [15:0] SW_CLA = 16'h6E00;
	localparam logic [15:0] SW_P1P2 = 16'h6A86;
	localparam logic [15:0] SW_LC = 16'h6700;
	localparam logic [15:0] SW_DATA = 16'h6A82;
	localparam logic [15:0] SW_LE = 16'h6C00;

	// CRC_A, reflected form
	localparam logic [15:0] CRC_INIT = 16'h6363;
	localparam logic [15:0] CRC_POLY = 16'h8408;

	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FILE = 8'h08;
	localparam logic [7:0] REG_COUNT = 8'h0C;

	typedef enum logic [2:0] {
		ERR_NONE = 3'b000,
		ERR_CLA = 3'b001,
		ERR_P1P2 = 3'b010,
		ERR_LC = 3'b011,
		ERR_DATA = 3'b100,
		ERR_LE = 3'b101
	} err_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_AID = 3'b001,
		SEL_CC = 3'b010,
		SEL_NDEF = 3'b011,
		SEL_EF = 3'b100
	} sel_t;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_ATS = 3'b001,
		TX_GAP = 3'b010,
		TX_CRC_LO = 3'b011,
		TX_CRC_HI = 3'b100,
		TX_SW_HI = 3'b101,
		TX_SW_LO = 3'b110
	} tx_state_t;

	// One byte on the frame link
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} link_byte_t;

endpackage

/* File: crc_a_calc.sv */
`timescale 1ns/100ps
module crc_a_calc
	import ats_sel_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic clr,
	input wire logic upd,
	input wire logic [7:0] din,
	output logic [15:0] crc
);

	logic [15:0] crc_q;
	logic [15:0] crc_d;

	// One byte through the reflected polynomial, LSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign crc_d = clr ? CRC_INIT : (upd ? crc_byte(crc_q, din) : crc_q);
	assign crc = crc_q;

	// Running remainder
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			crc_q <= CRC_INIT;
		else if (ce)
			crc_q <= crc_d;
	end

endmodule

/* File: reply_tx.sv */
`timescale 1ns/100ps
module reply_tx
	import ats_sel_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic start_ats,
	input wire logic start_sw,
	input wire logic [15:0] sw,
	input wire logic [3:0] fwi,
	input wire logic [15:0] crc,
	input wire logic tx_ready,
	output link_byte_t tx,
	output logic crc_clr,
	output logic crc_upd,
	output logic busy
);

	tx_state_t state_q, state_d;
	logic [2:0] idx_q; // Byte index inside the frame header
	logic [7:0] data_q; // Byte on the link
	logic [15:0] sw_q; // Held status word
	logic take; // Byte accepted by the link
	logic [7:0] ats_byte; // Next answer-to-select byte

	assign take = (state_q != TX_IDLE) && (state_q != TX_GAP) && tx_ready;
	assign busy = state_q != TX_IDLE;
	// Fixed answer apart from the wait index from fwi; no historical bytes follow TC
	assign ats_byte = (idx_q == 3'h1) ? ATS_TA :
		(idx_q == 3'h2) ? {fwi, ATS_SFGI} :
		(idx_q == 3'h3) ? ATS_TC : ATS_T0;
	assign tx.valid = (state_q != TX_IDLE) && (state_q != TX_GAP);
	assign tx.last = (state_q == TX_CRC_HI) || (state_q == TX_SW_LO);
	assign tx.data = data_q;
	assign crc_clr = start_ats && (state_q == TX_IDLE);
	assign crc_upd = take && (state_q == TX_ATS);

	// Next state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			TX_IDLE:
				if (start_ats)
					state_d = TX_ATS;
				else if (start_sw)
					state_d = TX_SW_HI;
			TX_ATS:
				if (take && idx_q == ATS_LAST)
					state_d = TX_GAP;
			TX_GAP:
				state_d = TX_CRC_LO; // Lets the remainder settle
			TX_CRC_LO:
				if (take)
					state_d = TX_CRC_HI;
			TX_CRC_HI:
				if (take)
					state_d = TX_IDLE;
			TX_SW_HI:
				if (take)
					state_d = TX_SW_LO;
			TX_SW_LO:
				if (take)
					state_d = TX_IDLE;
			default:
				state_d = TX_IDLE;
		endcase
	end

	// Sequencer and output byte
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= TX_IDLE;
			idx_q <= 3'h0;
			data_q <= 8'h00;
			sw_q <= 16'h0000;
		end
		else if (ce)
		begin
			state_q <= state_d;
			if (state_q == TX_IDLE && start_ats)
			begin
				idx_q <= 3'h0;
				data_q <= ATS_TL;
			end
			else if (state_q == TX_IDLE && start_sw)
			begin
				sw_q <= sw;
				data_q <= sw[15:8];
			end
			else if (state_q == TX_ATS && take)
			begin
				idx_q <= idx_q + 3'h1;
				data_q <= ats_byte;
			end
			else if (state_q == TX_GAP)
				data_q <= crc[7:0];
			else if (state_q == TX_CRC_LO && take)
				data_q <= crc[15:8];
			else if (state_q == TX_SW_HI && take)
				data_q <= sw_q[7:0];
		end
	end

endmodule

/* File: ats_sel.sv */
`timescale 1ns/100ps
// Operation
// - Answer starts with length byte 0x05
// - Format byte fixed at 0x78
// - First interface byte 0x80, 106 kbit/s
// - Second byte: wait index high, zero low
// - Third interface byte is 0x00
// - No historical bytes before the CRC
// - Select uses 0xA4; class other than 0x00 fails
// - P1 picks addressing: id, EF, application
// - P2 0x0C no control info, 0x00 file
// - Only pairs 020C, 0400, 000C accepted
// - Length 7 for application, else 2
// - Application data must match fixed name
// - Pair 000C selects CC or NDEF file
// - Pair 020C takes any identifier
// - Expected length only for application, 0x00
module ats_sel
	import ats_sel_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Frames from and to the RF front end
	input wire link_byte_t rx,
	input wire logic tx_ready,
	output link_byte_t tx,
	// Selection result for the file logic
	output logic sel_done,
	output sel_t sel_kind,
	output logic [15:0] file_id
);

	////////////////////////////////////////////////////////////////////
	// Registers and frame capture

	logic enable_q; // Block answers frames
	logic [3:0] fwi_q; // Frame waiting time index
	logic [7:0] cnt_q; // Bytes seen in this frame, saturating
	logic [7:0] cla_q;
	logic [7:0] ins_q;
	logic [7:0] p1_q;
	logic [7:0] p2_q;
	logic [7:0] lc_q;
	logic [7:0] le_q;
	logic [15:0] fid_q; // Two data bytes, first byte high
	logic data_bad_q; // Application name mismatch seen
	logic eval_q; // Frame ended last cycle
	err_t err_q; // Outcome of last select
	sel_t kind_q; // Last successful selection
	logic [15:0] file_q; // Identifier of last file selection
	logic [15:0] sel_cnt_q; // Select commands answered
	logic done_q;
	logic [31:0] rdata_q;
	logic busy; // Answer under way; read by decode and capture

	////////////////////////////////////////////////////////////////////
	// Register decode

	logic setup; // APB setup phase
	logic wr_ctrl;
	logic addr_ok;
	logic [3:0] fwi_wr;
	logic [31:0] rd_mux;

	assign setup = psel && !penable;
	assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
		(paddr == REG_FILE) || (paddr == REG_COUNT);
	// Zero wait states: data is staged during setup
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = rdata_q;
	assign wr_ctrl = psel && penable && pwrite && (paddr == REG_CTRL);
	// Out-of-range index is clamped so the answer stays legal
	assign fwi_wr = (pwdata[7:4] < FWI_MIN) ? FWI_MIN :
		(pwdata[7:4] > FWI_MAX) ? FWI_MAX : pwdata[7:4];

	assign rd_mux = (paddr == REG_CTRL) ?
			{24'h000000, fwi_q, 3'h0, enable_q} :
		(paddr == REG_STATUS) ?
			{23'h000000, busy, 1'h0, kind_q, 1'h0, err_q} :
		(paddr == REG_FILE) ? {16'h0000, file_q} :
		(paddr == REG_COUNT) ? {16'h0000, sel_cnt_q} : 32'h00000000;

	// Control register and read staging
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			enable_q <= 1'b1;
			fwi_q <= FWI_RST;
			rdata_q <= 32'h00000000;
		end
		else if (ce)
		begin
			if (wr_ctrl)
			begin
				enable_q <= pwdata[0];
				fwi_q <= fwi_wr;
			end
			if (setup && !pwrite)
				rdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Byte capture

	logic rx_take; // Byte accepted from the link
	logic [7:0] didx; // Data byte index
	logic in_data;
	logic [2:0] aid_pos;
	logic [7:0] aid_expect;
	logic pair_is_aid;

	// Frames are ignored while an answer is still going out
	assign rx_take = rx.valid && enable_q && !busy;
	assign didx = cnt_q - HDR_LEN;
	assign pair_is_aid = {p1_q, p2_q} == PAIR_AID;
	assign in_data = (cnt_q >= HDR_LEN) && (didx < lc_q);
	assign aid_pos = 3'h6 - didx[2:0];
	assign aid_expect = AID_VALUE[{aid_pos, 3'h0} +: 8];

	// Field capture by byte position
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 8'h00;
			cla_q <= 8'h00;
			ins_q <= 8'h00;
			p1_q <= 8'h00;
			p2_q <= 8'h00;
			lc_q <= 8'h00;
			le_q <= 8'h00;
			fid_q <= 16'h0000;
			data_bad_q <= 1'b0;
			eval_q <= 1'b0;
		end
		else if (ce)
		begin
			eval_q <= rx_take && rx.last;
			if (rx_take)
			begin
				// Next frame starts at index zero
				cnt_q <= rx.last ? 8'h00 :
					(cnt_q == 8'hFF ? cnt_q : cnt_q + 8'h01);
				case (cnt_q)
					8'h00:
					begin
						cla_q <= rx.data;
						data_bad_q <= 1'b0;
					end
					8'h01:
						ins_q <= rx.data;
					8'h02:
						p1_q <= rx.data;
					8'h03:
						p2_q <= rx.data;
					8'h04:
						lc_q <= rx.data;
					default:
						if (in_data)
						begin
							fid_q <= {fid_q[7:0], rx.data};
							if (pair_is_aid && didx < LC_AID &&
								rx.data != aid_expect)
								data_bad_q <= 1'b1;
						end
						else
							le_q <= rx.data;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Frame evaluation, one cycle after the last byte

	logic [7:0] len_q; // Length of the frame just ended
	logic [15:0] pair;
	logic pair_ok;
	logic [7:0] lc_exp;
	logic [7:0] base_len;
	logic lc_ok;
	logic le_seen;
	logic data_ok;
	logic le_ok;
	logic is_rats;
	logic is_select;
	err_t err;
	sel_t kind;
	logic [15:0] sw;

	// Length held past the counter reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			len_q <= 8'h00;
		else if (ce && rx_take)
			len_q <= (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
	end

	// Sorts an identifier into a file kind
	function automatic sel_t fid_kind(input logic [15:0] id);
		if (id == FID_CC)
			return SEL_CC;
		else if (id == FID_NDEF)
			return SEL_NDEF;
		else
			return SEL_NONE;
	endfunction

	assign pair = {p1_q, p2_q};
	assign pair_ok = (pair == PAIR_EF) || (pair == PAIR_AID) ||
		(pair == PAIR_FID);
	assign lc_exp = pair_is_aid ? LC_AID : LC_OTHER;
	assign base_len = HDR_LEN + lc_exp;
	assign lc_ok = (len_q >= HDR_LEN) && (lc_q == lc_exp);
	assign le_seen = len_q == base_len + 8'h01;
	// Pair 020C takes any identifier; 000C only the two files
	assign data_ok = (len_q >= base_len) && !data_bad_q &&
		((pair == PAIR_EF) || pair_is_aid ||
		(fid_kind(fid_q) != SEL_NONE));
	assign le_ok = (len_q == base_len) ||
		(le_seen && pair_is_aid && le_q == LE_AID);
	assign is_rats = (len_q == 8'h02) && (cla_q == RATS_START);
	assign is_select = (len_q >= 8'h02) && (ins_q == INS_SELECT);

	// Error priority follows field order
	assign err = (cla_q != CLA_ISO) ? ERR_CLA :
		!pair_ok ? ERR_P1P2 :
		!lc_ok ? ERR_LC :
		!data_ok ? ERR_DATA :
		!le_ok ? ERR_LE : ERR_NONE;

	assign kind = (err != ERR_NONE) ? SEL_NONE :
		pair_is_aid ? SEL_AID :
		(pair == PAIR_EF) ? SEL_EF : fid_kind(fid_q);

	assign sw = (err == ERR_CLA) ? SW_CLA :
		(err == ERR_P1P2) ? SW_P1P2 :
		(err == ERR_LC) ? SW_LC :
		(err == ERR_DATA) ? SW_DATA :
		(err == ERR_LE) ? SW_LE : SW_OK;

	logic start_ats;
	logic start_sw;

	// Other instructions belong to other command logic
	assign start_ats = eval_q && is_rats;
	assign start_sw = eval_q && !is_rats && is_select;

	// Outcome and selection record
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_q <= ERR_NONE;
			kind_q <= SEL_NONE;
			file_q <= 16'h0000;
			sel_cnt_q <= 16'h0000;
			done_q <= 1'b0;
		end
		else if (ce)
		begin
			done_q <= start_sw && (kind != SEL_NONE);
			if (start_sw)
			begin
				err_q <= err;
				sel_cnt_q <= sel_cnt_q + 16'h0001;
				if (kind != SEL_NONE)
				begin
					// Failed selects leave the old file in place
					kind_q <= kind;
					if (!pair_is_aid)
						file_q <= fid_q;
				end
			end
		end
	end

	assign sel_done = done_q;
	assign sel_kind = kind_q;
	assign file_id = file_q;

	////////////////////////////////////////////////////////////////////
	// Answer path

	logic crc_clr;
	logic crc_upd;
	logic [15:0] crc;

	reply_tx u_reply
	(
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.start_ats(start_ats),
		.start_sw(start_sw),
		.sw(sw),
		.fwi(fwi_q),
		.crc(crc),
		.tx_ready(tx_ready),
		.tx(tx),
		.crc_clr(crc_clr),
		.crc_upd(crc_upd),
		.busy(busy)
	);

	// Remainder runs over the answer bytes only
	crc_a_calc u_crc
	(
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.clr(crc_clr),
		.upd(crc_upd),
		.din(tx.data),
		.crc(crc)
	);

endmodule

/* File: ats_sel_sva.sv */
`timescale 1ns/100ps
module ats_sel_sva
	import ats_sel_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire link_byte_t rx,
	input wire logic tx_ready,
	input wire link_byte_t tx,
	input wire logic sel_done,
	input wire sel_t sel_kind,
	input wire logic [15:0] file_id
);
	logic [3:0] cnt_q; // Bytes seen so far in this rx frame
	logic [7:0] prev_q; // Previous rx byte
	logic ins_q; // Frame carries the select code
	logic ats_q; // Answer under way is the ATS
	logic [2:0] n_q; // Answer bytes already taken
	// Last byte taken while idle; frames sent when busy are not judged
	wire rx_end = rx.valid && rx.last && ce && !tx.valid;
	wire mapped = paddr[1:0] == 2'b00 && paddr <= 8'h0C;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////
	// Track frame position on both sides of the link
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 4'h0;
			prev_q <= 8'h00;
			ins_q <= 1'b0;
			ats_q <= 1'b0;
			n_q <= 3'h0;
		end
		else
		begin
			if (rx.valid) cnt_q <= rx.last ? 4'h0 : cnt_q + 4'h1;
			if (rx.valid) prev_q <= rx.data;
			if (rx.valid && cnt_q == 4'h1) ins_q <= rx.data == 8'hA4;
			if (rx.valid && rx.last) ats_q <= cnt_q == 4'h1 && prev_q == 8'hE0;
			if (tx.valid && tx_ready) n_q <= tx.last ? 3'h0 : n_q + 3'h1;
		end
	end
	////////////////////
	a_rats_reply: assert property (rx_end && cnt_q == 4'h1
		&& prev_q == 8'hE0 |-> ##2 tx.valid && tx.data == 8'h05)
		else $error("ats missing or without its length");
	a_fmt_byte: assert property (ats_q && tx.valid && n_q == 3'h1
		|-> tx.data == 8'h78) else $error("bad format byte");
	a_rate_byte: assert property (ats_q && tx.valid && n_q == 3'h2
		|-> tx.data == 8'h80) else $error("bad rate byte");
	a_wait_byte: assert property (ats_q && tx.valid && n_q == 3'h3
		|-> tx.data[7:4] inside {[4'h1:4'hE]} && tx.data[3:0] == 4'h0)
		else $error("bad wait byte");
	a_opt_byte: assert property (ats_q && tx.valid && n_q == 3'h4
		|-> tx.data == 8'h00 && !tx.last) else $error("bad option byte");
	a_crc_gap: assert property (ats_q && tx.valid && tx_ready
		&& n_q == 3'h4 |=> !tx.valid ##1 tx.valid)
		else $error("no single idle cycle before checksum");
	a_no_hist: assert property (ats_q && tx.valid && tx.last
		|-> n_q == 3'h6) else $error("ats has wrong length");
	a_sw_timely: assert property (rx_end && cnt_q >= 4'h2 && ins_q
		|-> ##2 tx.valid) else $error("select not answered in time");
	a_sw_pair: assert property (!ats_q && tx.valid && tx.last
		|-> n_q == 3'h1) else $error("status answer not two bytes");
	a_done_ok: assert property (sel_done
		|-> tx.valid && tx.data == 8'h90 && n_q == 3'h0)
		else $error("success pulse without success status");
	a_bus_err: assert property (psel && penable
		|-> pready && pslverr == !mapped) else $error("bad bus answer");
	c_ats: cover property (ats_q && tx.valid && tx.last);
	c_done: cover property (sel_done);
	c_bus_err: cover property (pslverr);
endmodule

/* File: rf_reader.sv */
`timescale 1ns/100ps
module rf_reader
	import ats_sel_pkg::*;
(
	input wire logic clk,
	input wire link_byte_t tx,
	input wire logic slow,
	output link_byte_t rx,
	output logic tx_ready
);
	logic [7:0] resp[$]; // Answer bytes as taken
	int n_frames = 0; // Answers completed
	logic ph_q = 1'b0; // Stall phase
	initial rx = '0;
	initial tx_ready = 1'b1;
	////////////////////
	// Take answer bytes; a slow reader stalls every other cycle
	always @(posedge clk)
	begin
		ph_q <= ~ph_q;
		tx_ready <= !slow || ph_q;
		if (tx.valid && tx_ready)
		begin
			resp.push_back(tx.data);
			if (tx.last) n_frames++;
		end
	end
	// Send one frame, a byte per cycle; the caller stands at an edge
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i])
		begin
			rx <= '{1'b1, i == f.size() - 1, f[i]};
			@(posedge clk);
		end
		// Released line shows no stale byte
		rx <= '{1'b0, 1'b0, ~f[f.size() - 1]};
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench
	import ats_sel_pkg::*;
;
	logic clk, arst_n, ce, psel, penable, pwrite, pready, pslverr;
	logic sel_done, slow, tx_ready, e1;
	logic [2:0] kk; // Kind of the last successful select
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	link_byte_t rx, tx;
	sel_t sel_kind;
	logic [15:0] file_id, fid, pp;
	logic [63:0] d;
	int n_errors = 0, checks = 0, n_sel = 0;
	int seed = 32'h435853be;
	logic [15:0] pt[5] = '{16'h020C, 16'h0400, 16'h000C, 16'h0000, 16'h040C};
	logic [7:0] lt[3] = '{8'h02, 8'h07, 8'h03};
	logic [63:0] dt[4] = '{64'hD2760000850101, 0, 64'hE103, 64'h0103};
	ats_sel u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
		.tx_ready(tx_ready), .tx(tx), .sel_done(sel_done),
		.sel_kind(sel_kind), .file_id(file_id));
	rf_reader u_rdr (.clk(clk), .tx(tx), .slow(slow), .rx(rx),
		.tx_ready(tx_ready));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One bus transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd_v, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] v;
		logic e;
		apb(1'b0, a, 32'h0, v, e);
		check(v, x);
		check(32'(e), 32'(xe));
	endtask
	// Wait up to 80 cycles for the first whole answer, then expect n
	task automatic answer(input int n);
		int k;
		k = u_rdr.n_frames;
		repeat (80) if (u_rdr.n_frames == k) @(posedge clk);
		check(u_rdr.n_frames, k + n);
		repeat (4) @(posedge clk);
	endtask
	function automatic logic [15:0] crc_a(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'h6363;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		return c;
	endfunction
	// Status and selected kind, validated in priority order
	function automatic logic [18:0] expect_sel(input logic [7:0] cla,
		input logic [15:0] p, input logic [7:0] lc, input logic [55:0] dv,
		input logic nle, input logic [7:0] le);
		if (cla != 8'h00) return {SEL_NONE, SW_CLA};
		if (p != 16'h020C && p != 16'h0400 && p != 16'h000C)
			return {SEL_NONE, SW_P1P2};
		if (lc != (p == 16'h0400 ? 8'h07 : 8'h02))
			return {SEL_NONE, SW_LC};
		if (p == 16'h0400 && dv != 56'hD2760000850101)
			return {SEL_NONE, SW_DATA};
		if (p == 16'h000C && dv[15:0] != 16'hE103 && dv[15:0] != 16'h0103)
			return {SEL_NONE, SW_DATA};
		if (nle && (p != 16'h0400 || le != 8'h00))
			return {SEL_NONE, SW_LE};
		if (p == 16'h0400) return {SEL_AID, SW_OK};
		if (p == 16'h020C) return {SEL_EF, SW_OK};
		return {dv[15:0] == 16'hE103 ? SEL_CC : SEL_NDEF, SW_OK};
	endfunction
	// Error class that the status register reports for a status word
	function automatic logic [2:0] err_code(input logic [15:0] s);
		return s == SW_CLA ? ERR_CLA : s == SW_P1P2 ? ERR_P1P2 :
			s == SW_LC ? ERR_LC : s == SW_DATA ? ERR_DATA :
			s == SW_LE ? ERR_LE : ERR_NONE;
	endfunction
	task automatic sel(input logic [7:0] cla, input logic [15:0] p,
		input logic [7:0] lc, input logic [55:0] dv, input logic nle,
		input logic [7:0] le);
		logic [7:0] f[$];
		logic [18:0] x;
		x = expect_sel(cla, p, lc, dv, nle, le);
		f = '{cla, 8'hA4, p[15:8], p[7:0], lc};
		for (int i = lc - 1; i >= 0; i--) f.push_back(dv[8 * i +: 8]);
		if (nle) f.push_back(le);
		u_rdr.resp.delete();
		u_rdr.send(f);
		answer(1);
		n_sel++;
		check(u_rdr.resp.size(), 2);
		check({u_rdr.resp[0], u_rdr.resp[1]}, x[15:0]);
		if (x[15:0] == SW_OK) check(32'(sel_kind), 32'(x[18:16]));
		if (x[15:0] == SW_OK && x[18:16] != SEL_AID) fid = dv[15:0];
		check(file_id, fid);
		if (x[15:0] == SW_OK) kk = x[18:16];
		rd(REG_STATUS, {25'h0, kk, 1'b0, err_code(x[15:0])}, 1'b0);
	endtask
	task automatic rats(input logic [3:0] fw);
		logic [7:0] e[$];
		logic [15:0] c;
		logic [3:0] w;
		logic er;
		w = fw == 4'h0 ? 4'h1 : fw == 4'hF ? 4'hE : fw;
		apb(1'b1, REG_CTRL, {24'h0, fw, 4'h1}, r, er);
		rd(REG_CTRL, {24'h0, w, 4'h1}, 1'b0);
		e = '{8'h05, 8'h78, 8'h80, {w, 4'h0}, 8'h00};
		c = crc_a(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		u_rdr.resp.delete();
		u_rdr.send('{8'hE0, 8'($random(seed))});
		answer(1);
		check(u_rdr.resp.size(), 7);
		foreach (e[i]) check(u_rdr.resp[i], e[i]);
	endtask
	////////////////////
	initial
	begin
		arst_n = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow = 1'b0;
		fid = 16'h0000;
		kk = 3'h0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(REG_CTRL, 32'h41, 1'b0);
		// Frozen block must ignore a control write
		ce <= 1'b0;
		apb(1'b1, REG_CTRL, 32'h0, r, e1);
		ce <= 1'b1;
		rd(REG_CTRL, 32'h41, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		rats(4'h0);
		rats(4'hF);
		slow <= 1'b1;
		rats(4'hE);
		rats(4'($random(seed)));
		// Corner selects first, then random ones
		sel(8'h00, 16'h0400, 8'h07, 56'hD2760000850101, 1'b1, 8'h00);
		sel(8'h00, 16'h000C, 8'h02, 56'hE103, 1'b0, 8'h00);
		sel(8'h00, 16'h000C, 8'h02, 56'h0103, 1'b0, 8'h00);
		sel(8'h00, 16'h000C, 8'h02, 56'h1234, 1'b0, 8'h00);
		sel(8'h00, 16'h0400, 8'h07, 56'hD2760000850101, 1'b1, 8'h01);
		sel(8'h80, 16'h0400, 8'h07, 56'hD2760000850101, 1'b0, 8'h00);
		// Other instruction gets no answer
		u_rdr.send('{8'h00, 8'hB0, 8'h00, 8'h00, 8'h02});
		answer(0);
		repeat (40)
		begin
			r = $random(seed);
			slow <= r[0];
			pp = pt[r[3:1] % 5];
			d = r[6:5] == 2'h1 ? {$random(seed), $random(seed)} : dt[r[6:5]];
			sel(r[11:9] == 3'h0 ? r[19:12] : 8'h00, pp, lt[r[8:7] % 3],
				d[55:0], r[20], r[21] ? r[29:22] : 8'h00);
		end
		apb(1'b1, REG_COUNT, 32'hFFFF, r, e1);
		check(32'(e1), 32'h0);
		rd(REG_COUNT, 32'(n_sel), 1'b0);
		rd(REG_FILE, {16'h0, fid}, 1'b0);
		finish_test();
	end
	initial
	begin
		#(40 * 20000);
		n_errors++;
		finish_test();
	end
endmodule
bind ats_sel ats_sel_sva u_sva (.clk, .arst_n, .ce, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx, .tx_ready,
	.tx, .sel_done, .sel_kind, .file_id);
